// ==== design/pcp_prescaler_top.sv ====
// PWM clock prescaler with APB registers and per-channel clock selection.
//
// Added by the designer: the APB interface to the registers and the address map.
module pcp_prescaler_top
    import pcp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic freeze_in,
    output logic clk_a_en,
    output logic clk_b_en,
    output logic scaled_clk_a_en,
    output logic scaled_clk_b_en,
    output logic [NUM_CH-1:0] chan_clk_en
);
    logic freeze_stop_enable;
    logic [NUM_CH-1:0] channel_enable_bits;
    logic [2:0] clk_a_div_sel;
    logic [2:0] clk_b_div_sel;
    logic [SCALE_W-1:0] scale_a;
    logic [SCALE_W-1:0] scale_b;
    logic [NUM_CH*SEL_W-1:0] clk_sel;
    logic [PRE_W-1:0] pre_cnt;
    logic frz_q1;
    logic frz_q2;
    logic frz_q3;
    logic frz_level;

    pcp_scale_if sif_a();
    pcp_scale_if sif_b();

    // Bus decode.
    wire setup;
    wire access;
    wire hit_ctrl;
    wire hit_pre;
    wire hit_sa;
    wire hit_sb;
    wire hit_sel;
    wire hit_stat;
    wire mapped;
    wire wr;
    wire wr_ctrl;
    wire wr_pre;
    wire wr_sa;
    wire wr_sb;
    wire wr_sel;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_ctrl = (paddr == OFF_CTRL);
    assign hit_pre = (paddr == OFF_PRESCALE);
    assign hit_sa = (paddr == OFF_SCALE_A);
    assign hit_sb = (paddr == OFF_SCALE_B);
    assign hit_sel = (paddr == OFF_CLK_SEL);
    assign hit_stat = (paddr == OFF_STATUS);
    assign mapped = hit_ctrl || hit_pre || hit_sa || hit_sb || hit_sel || hit_stat;
    // Writes land in the access cycle only, so each register sees one strobe per transfer.
    assign wr = access && pwrite && mapped;
    assign wr_ctrl = wr && hit_ctrl;
    assign wr_pre = wr && hit_pre;
    assign wr_sa = wr && hit_sa;
    assign wr_sb = wr && hit_sb;
    assign wr_sel = wr && hit_sel;

    // No register needs a wait state, so the slave always answers at once.
    assign pready = 1'b1;
    // An unmapped address is flagged in the access cycle and its write is dropped.
    assign pslverr = access && !mapped;

    // Prescaler input gating.
    wire frozen;
    wire any_enabled;
    wire input_en;
    // R9: freeze stops input
    assign frozen = freeze_stop_enable && frz_level;
    // R10: all channels off
    assign any_enabled = (channel_enable_bits != '0);
    // R1: single bus clock source
    assign input_en = !frozen && any_enabled;

    wire [PRE_W-1:0] mask_a;
    wire [PRE_W-1:0] mask_b;
    wire tick_a;
    wire tick_b;
    // R11: code n masks n low bits
    assign mask_a = PRE_W'((8'h01 << clk_a_div_sel) - 8'h01);
    assign mask_b = PRE_W'((8'h01 << clk_b_div_sel) - 8'h01);
    // R3: divide by power of two
    // A code change acts at once, so the first pulse at a new ratio may come early.
    assign tick_a = input_en && ((pre_cnt & mask_a) == mask_a);
    assign tick_b = input_en && ((pre_cnt & mask_b) == mask_b);

    // R7: scalers ticked by A and B
    assign sif_a.tick = tick_a;
    assign sif_a.reload = scale_a;
    assign sif_b.tick = tick_b;
    assign sif_b.reload = scale_b;

    // Each divider counts only on its own prescaled pulse, so gating stops it as well.
    // R5: scaled A divider
    pcp_scaler u_scale_a (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif_a.scaler)
    );

    // R6: scaled B divider
    pcp_scaler u_scale_b (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif_b.scaler)
    );

    // R8: per-channel clock choice
    wire [NUM_CH-1:0] next_chan;
    for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
        wire [SEL_W-1:0] code;
        wire pick_a;
        wire pick_b;
        wire pick_sa;
        wire pick_sb;
        assign code = clk_sel[i*SEL_W +: SEL_W];
        assign pick_a = (code == SEL_A) && tick_a;
        assign pick_b = (code == SEL_B) && tick_b;
        assign pick_sa = (code == SEL_SA) && sif_a.out_tick;
        assign pick_sb = (code == SEL_SB) && sif_b.out_tick;
        assign next_chan[i] = pick_a || pick_b || pick_sa || pick_sb;
    end

    // Read data multiplexer.
    wire [31:0] rd_ctrl;
    wire [31:0] rd_pre;
    wire [31:0] rd_stat;
    wire [31:0] next_rdata;
    assign rd_ctrl = 32'({channel_enable_bits, 7'h00, freeze_stop_enable});
    // R4: two three-bit fields
    assign rd_pre = 32'({1'b0, clk_b_div_sel, 1'b0, clk_a_div_sel});
    assign rd_stat = 32'({frz_level, input_en, 1'b0, pre_cnt});
    assign next_rdata = hit_ctrl ? rd_ctrl :
                             hit_pre ? rd_pre :
                             hit_sa ? 32'(scale_a) :
                             hit_sb ? 32'(scale_b) :
                             hit_sel ? 32'(clk_sel) :
                             hit_stat ? rd_stat : 32'h0000_0000;

    // Read data is captured in setup so it already stands when the access cycle samples it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // Register writes, one short process per register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freeze_stop_enable <= RST_CTRL[CTRL_FRZ_BIT];
            channel_enable_bits <= RST_CTRL[CTRL_EN_LSB +: NUM_CH];
        end else if (wr_ctrl) begin
            freeze_stop_enable <= pwdata[CTRL_FRZ_BIT];
            channel_enable_bits <= pwdata[CTRL_EN_LSB +: NUM_CH];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_a_div_sel <= RST_PRE_SEL;
            clk_b_div_sel <= RST_PRE_SEL;
        end else if (wr_pre) begin
            clk_a_div_sel <= pwdata[PRE_A_LSB +: 3];
            clk_b_div_sel <= pwdata[PRE_B_LSB +: 3];
        end
    end

    // A new scale value is used from the divider's next terminal count on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scale_a <= RST_SCALE;
        end else if (wr_sa) begin
            scale_a <= pwdata[SCALE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scale_b <= RST_SCALE;
        end else if (wr_sb) begin
            scale_b <= pwdata[SCALE_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel <= RST_CLK_SEL;
        end else if (wr_sel) begin
            clk_sel <= pwdata[NUM_CH*SEL_W-1:0];
        end
    end

    // Freeze arrives from outside the block, so it is filtered by three flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frz_q1 <= 1'b0;
            frz_q2 <= 1'b0;
            frz_q3 <= 1'b0;
        end else begin
            frz_q1 <= freeze_in;
            frz_q2 <= frz_q1;
            frz_q3 <= frz_q2;
        end
    end

    // A pulse that the second and third stage do not both see is ignored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frz_level <= 1'b0;
        end else if (frz_q2 == frz_q3) begin
            frz_level <= frz_q3;
        end
    end

    // R10: counter holds when gated
    // The counter is never cleared when gated, so every code keeps its phase across a pause.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= RST_PRE_CNT;
        end else if (input_en) begin
            pre_cnt <= PRE_W'(pre_cnt + 1'b1);
        end
    end

    // R2: four clock enables out
    // Every enable is registered so that consumers see clean single-cycle pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_a_en <= 1'b0;
        end else begin
            clk_a_en <= tick_a;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_b_en <= 1'b0;
        end else begin
            clk_b_en <= tick_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scaled_clk_a_en <= 1'b0;
        end else begin
            scaled_clk_a_en <= sif_a.out_tick;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scaled_clk_b_en <= 1'b0;
        end else begin
            scaled_clk_b_en <= sif_b.out_tick;
        end
    end

    // Channel pulses share the register stage of the sources, so they line up with them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_clk_en <= '0;
        end else begin
            chan_clk_en <= next_chan;
        end
    end
endmodule

// ==== design/pcp_pkg.sv ====
// Constants, offsets and field layouts for the PWM clock prescaler.
// Contract
// R1: Every PWM clock enable is derived from the single bus clock pclk.
// R2: The block makes exactly four channel clocks: A, B, scaled A and scaled B.
// R3: Clocks A and B each run at the bus rate divided by 1, 2, 4, 8, 16, 32, 64 or 128.
// R4: Clock A takes its ratio from one three-bit field of the prescale register and clock B from another.
// R5: Scaled A divides clock A by a programmed value and then by two, giving even ratios 2 to 512.
// R6: Scaled B divides clock B the same way with its own programmed value.
// R7: Scaled division uses a counter ticked by its prescaled clock that reloads at terminal count.
// R8: Each PWM channel selects its own one of the four clocks.
// R9: With the freeze stop enable set and freeze active, the prescaler input is stopped.
// R10: With every channel enable bit zero, the prescaler input is gated off.
// R11: Prescale code n divides by two to the power n, code zero passing the bus clock.
package pcp_pkg;
    localparam int NUM_CH = 8;
    localparam int PRE_W = 7;
    localparam int SCALE_W = 8;
    localparam int SEL_W = 2;

    localparam logic [11:0] OFF_CTRL = 12'h0000;
    localparam logic [11:0] OFF_PRESCALE = 12'h0004;
    localparam logic [11:0] OFF_SCALE_A = 12'h0008;
    localparam logic [11:0] OFF_SCALE_B = 12'h000c;
    localparam logic [11:0] OFF_CLK_SEL = 12'h0010;
    localparam logic [11:0] OFF_STATUS = 12'h0014;

    localparam int CTRL_FRZ_BIT = 0;
    localparam int CTRL_EN_LSB = 8;
    localparam int PRE_A_LSB = 0;
    localparam int PRE_B_LSB = 4;
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_RUN_BIT = 8;
    localparam int STAT_FRZ_BIT = 9;

    localparam logic [SEL_W-1:0] SEL_A = 2'h0;
    localparam logic [SEL_W-1:0] SEL_B = 2'h1;
    localparam logic [SEL_W-1:0] SEL_SA = 2'h2;
    localparam logic [SEL_W-1:0] SEL_SB = 2'h3;

    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [2:0] RST_PRE_SEL = 3'h0;
    localparam logic [SCALE_W-1:0] RST_SCALE = 8'h01;
    localparam logic [SCALE_W-1:0] RST_SCALE_CNT = 8'h00;
    localparam logic [NUM_CH*SEL_W-1:0] RST_CLK_SEL = 16'h0000;
    localparam logic [PRE_W-1:0] RST_PRE_CNT = 7'h00;
endpackage

// ==== design/pcp_scale_if.sv ====
// Link between the prescaler core and one scaled-clock divider.
interface pcp_scale_if;
    import pcp_pkg::*;
    logic tick;
    logic [SCALE_W-1:0] reload;
    logic [SCALE_W-1:0] count;
    logic out_tick;
    modport core (output tick, output reload, input count, input out_tick);
    modport scaler (input tick, input reload, output count, output out_tick);
endinterface

// ==== design/pcp_scaler.sv ====
// Reloadable even divider that turns a prescaled clock enable into a scaled one.
module pcp_scaler
    import pcp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    pcp_scale_if.scaler sif
);
    logic [SCALE_W-1:0] cnt;
    logic half;
    logic terminal;
    logic [SCALE_W-1:0] next_cnt;

    // A reload value of zero wraps to a full count of 256.
    assign terminal = (cnt == '0);
    // R7: reload at terminal
    assign next_cnt = terminal ? SCALE_W'(sif.reload - 1'b1) : SCALE_W'(cnt - 1'b1);
    // R5: final divide by two
    assign sif.out_tick = sif.tick && terminal && half;
    assign sif.count = cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= RST_SCALE_CNT;
            half <= 1'b0;
        end else if (sif.tick) begin
            cnt <= next_cnt;
            if (terminal) begin
                half <= ~half;
            end
        end
    end
endmodule

// ==== test/pcp_chan_model.sv ====
// Behavioural PWM channel counters fed by the selected clock enables.
module pcp_chan_model
(
    input wire logic pclk,
    input wire logic clr,
    input wire logic [7:0] ticks,
    output int cnt [8]
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge pclk) begin
        foreach (cnt[i]) begin
            cnt[i] <= clr ? 0 : cnt[i] + int'(ticks[i]);
        end
    end
endmodule

// ==== test/pcp_prescaler_checker.sv ====
// Port-level assertions for the PWM clock prescaler.
module pcp_prescaler_checker
    import pcp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic freeze_in,
    input wire logic clk_a_en,
    input wire logic clk_b_en,
    input wire logic scaled_clk_a_en,
    input wire logic scaled_clk_b_en,
    input wire logic [NUM_CH-1:0] chan_clk_en
);
    logic [31:0] ctrl_q;
    logic [2:0] pre_a_q;
    wire logic wr_acc = psel && penable && pwrite;
    wire logic idle = ctrl_q[15:8] == 8'h00;
    wire logic run0 = !ctrl_q[0] && !idle && pre_a_q == 3'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h0000_0000;
            pre_a_q <= 3'h0;
        end else if (wr_acc && paddr == OFF_CTRL) begin
            ctrl_q <= pwdata;
        end else if (wr_acc && paddr == OFF_PRESCALE) begin
            pre_a_q <= pwdata[2:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_idle2;
        idle ##1 idle;
    endsequence
    sequence s_frozen;
        (ctrl_q[0] && freeze_in) [*7];
    endsequence
    gate_off_a: assert property (s_idle2 |-> !clk_a_en && !clk_b_en)
        else $error("clock pulse with all channels off");
    freeze_stop_a: assert property (s_frozen |-> !clk_a_en && !clk_b_en)
        else $error("clock pulse while frozen");
    div_one_a: assert property (run0 ##1 run0 |-> clk_a_en)
        else $error("code zero missed a pulse");
    chan_src_a: assert property (|chan_clk_en |-> clk_a_en || clk_b_en || scaled_clk_a_en || scaled_clk_b_en)
        else $error("channel pulse without source");
    sa_src_a: assert property (scaled_clk_a_en |-> clk_a_en || $past(clk_a_en) || $past(clk_a_en, 2))
        else $error("scaled a without clock a");
    sb_src_a: assert property (scaled_clk_b_en |-> clk_b_en || $past(clk_b_en) || $past(clk_b_en, 2))
        else $error("scaled b without clock b");
    sa_gap_a: assert property (scaled_clk_a_en |=> !scaled_clk_a_en)
        else $error("scaled a ratio below two");
    sb_gap_a: assert property (scaled_clk_b_en |=> !scaled_clk_b_en)
        else $error("scaled b ratio below two");
endmodule
bind pcp_prescaler_top pcp_prescaler_checker u_pcp_prescaler_checker (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .freeze_in, .clk_a_en, .clk_b_en, .scaled_clk_a_en, .scaled_clk_b_en, .chan_clk_en);

// ==== test/test_pwm_clock_prescaler.sv ====
// Self-checking bench for the PWM clock prescaler.
module test_pwm_clock_prescaler
    import pcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic freeze_in = 1'h0, clr = 1'h0, pready, pslverr, err;
    logic clk_a_en, clk_b_en, scaled_clk_a_en, scaled_clk_b_en;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [NUM_CH-1:0] chan_clk_en;
    int failures = 0, n_compared = 0, c[4], ch[8];
    pcp_prescaler_top u_pcp_prescaler_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .freeze_in, .clk_a_en, .clk_b_en, .scaled_clk_a_en, .scaled_clk_b_en, .chan_clk_en);
    pcp_chan_model u_pcp_chan_model (.pclk, .clr, .ticks(chan_clk_en), .cnt(ch));
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    // Counts the four clock enables here and the channel enables in the model.
    task automatic count(input int n);
        c = '{default: 0};
        clr <= 1'h1;
        @(posedge pclk);
        clr <= 1'h0;
        repeat (n) begin
            @(posedge pclk);
            c[0] += int'(clk_a_en === 1'h1);
            c[1] += int'(clk_b_en === 1'h1);
            c[2] += int'(scaled_clk_a_en === 1'h1);
            c[3] += int'(scaled_clk_b_en === 1'h1);
        end
        #1;
    endtask
    task automatic t_regs();
        xfer(1'h0, OFF_SCALE_B, 32'h0000_0000);
        chk("scale_b", 32'h0000_0001, rd);
        xfer(1'h0, 12'h0ff0, 32'h0000_0000);
        chk("bad err", 32'h0000_0001, {31'h0, err});
        chk("bad data", 32'h0000_0000, rd);
        $display("t_regs done");
    endtask
    task automatic t_pre();
        xfer(1'h1, OFF_CTRL, 32'h0000_0100);
        for (int n = 0; n < 8; n++) begin
            xfer(1'h1, OFF_PRESCALE, 32'(n | (7 - n) << 4));
            count(256);
            chk("clk_a", 256 >> n, c[0]);
            chk("clk_b", 256 >> (7 - n), c[1]);
        end
        $display("t_pre done");
    endtask
    task automatic t_scale();
        xfer(1'h1, OFF_PRESCALE, 32'h0000_0000);
        xfer(1'h1, OFF_SCALE_A, 32'h0000_0003);
        repeat (20) @(posedge pclk);
        count(384);
        chk("sa", 64, c[2]);
        chk("sb", 192, c[3]);
        xfer(1'h1, OFF_SCALE_A, 32'h0000_0000);
        repeat (600) @(posedge pclk);
        count(1024);
        chk("sa max", 2, c[2]);
        $display("t_scale done");
    endtask
    task automatic t_sel();
        int e[4] = '{128, 64, 64, 32};
        xfer(1'h1, OFF_CTRL, 32'h0000_ff00);
        xfer(1'h1, OFF_PRESCALE, 32'h0000_0021);
        xfer(1'h1, OFF_SCALE_A, 32'h0000_0001);
        xfer(1'h1, OFF_CLK_SEL, 32'h0000_e4e4);
        repeat (600) @(posedge pclk);
        count(256);
        for (int i = 0; i < 8; i++) chk("chan", e[i % 4], ch[i]);
        $display("t_sel done");
    endtask
    task automatic t_gate();
        xfer(1'h1, OFF_CTRL, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        count(64);
        chk("gated", 0, c[0] + c[1] + c[2] + c[3]);
        $display("t_gate done");
    endtask
    task automatic t_frz();
        xfer(1'h1, OFF_CTRL, 32'h0000_0101);
        freeze_in <= 1'h1;
        repeat (8) @(posedge pclk);
        count(64);
        chk("frozen", 0, c[0] + c[1]);
        xfer(1'h1, OFF_CTRL, 32'h0000_0100);
        count(64);
        chk("unfrozen", 32, c[0]);
        freeze_in <= 1'h0;
        $display("t_frz done");
    endtask
    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_pre();
        t_scale();
        t_sel();
        t_gate();
        t_frz();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        complete_run();
    end
endmodule
